// [hdl/asp_pkg.sv]
// Behaviour
// [R1] async full duplex, sync half duplex modes
// [R2] sync: 8-bit half duplex, own shift clock
// [R3] async frame 8 or 9 bits, LSB first
// [R4] parity appended on send, checked on receive
// [R5] one or two stop bits, both ends
// [R6] flag parity, framing and overrun errors
// [R7] buffer register before each shift register
// [R8] multiprocessor mode keeps only address characters; the code filters only 9-bit async frames and keeps every 8-bit frame
// [R9] loop-back routes transmitter into receiver
// [R10] 13-bit reload counter after fractional prescaler
// [R11] event when transmit buffer becomes empty
// [R12] event when last frame bit sent
// [R13] event when character enters receive buffer
// [R14] event on framing, parity or overrun
// [R15] async fastest bit: sixteen module clocks
// [R16] sync fastest bit: eight module clocks
// [R17] idle high, single low start bit
// [R18] centre sampling, sixteenfold oversampling, majority vote
package asp_pkg;
   // ***************
   // register map
   // ***************
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_BAUD   = 8'h04;
   localparam logic [7:0] OFF_FRAC   = 8'h08;
   localparam logic [7:0] OFF_TXDATA = 8'h0c;
   localparam logic [7:0] OFF_RXDATA = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;
   localparam logic [7:0] OFF_ISTAT  = 8'h18;
   localparam logic [7:0] OFF_IMASK  = 8'h1c;

   // control bits
   localparam int CB_SYNC  = 0;
   localparam int CB_NINE  = 1;
   localparam int CB_PAR   = 2;
   localparam int CB_ODD   = 3;
   localparam int CB_STOP2 = 4;
   localparam int CB_MP    = 5;
   localparam int CB_LOOP  = 6;
   localparam int CB_REN   = 7;
   localparam int CB_RUN   = 8;
   localparam int CTRL_W   = 9;

   // interrupt status bits
   localparam int IB_TBE   = 0;
   localparam int IB_TLAST = 1;
   localparam int IB_RBF   = 2;
   localparam int IB_PE    = 3;
   localparam int IB_FE    = 4;
   localparam int IB_OE    = 5;
   localparam int IRQ_W    = 6;

   localparam int BAUD_W_DEF = 13;
   localparam int FRAC_W_DEF = 10;

   localparam logic [CTRL_W-1:0]   CTRL_RST = 9'h000;
   localparam logic [IRQ_W-1:0]    MASK_RST = 6'h00;
   localparam logic [FRAC_W_DEF:0] FRAC_RST = 11'h400;

   // ticks within one bit, then last data bit numbers
   localparam logic [3:0] OVS_LAST  = 4'hf;
   localparam logic [3:0] VOTE_A    = 4'h7;
   localparam logic [3:0] VOTE_B    = 4'h8;
   localparam logic [3:0] VOTE_C    = 4'h9;
   localparam logic [3:0] SYNC_RISE = 4'h3;
   localparam logic [3:0] SYNC_LAST = 4'h7;
   localparam logic [3:0] LAST8     = 4'h7;
   localparam logic [3:0] LAST9     = 4'h8;

   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_SYNC} asp_tx_t;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} asp_rx_t;
endpackage

// [hdl/asp_baud_gen.sv]
`timescale 1ns/1ns
module asp_baud_gen #(
   parameter int CNT_W  = 13,
   parameter int FRAC_W = 10
) (
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic              enable,
   input  wire logic [CNT_W-1:0]  reload,
   input  wire logic [FRAC_W:0]   fracStep,
   output      logic              tick
);
   if (CNT_W < 1 || CNT_W > 16 || FRAC_W < 2 || FRAC_W > 16) begin : gCheck
      $error("asp_baud_gen: unsupported width");
   end

   logic [FRAC_W-1:0] acc_r, acc_nxt;
   logic [CNT_W-1:0]  cnt_r, cnt_nxt;
   logic              tick_r, tick_nxt;
   logic [FRAC_W:0]   sum;

   // fractional prescaler feeds the reload counter
   always_comb begin
      sum      = {1'b0, acc_r} + fracStep;
      acc_nxt  = sum[FRAC_W-1:0];
      cnt_nxt  = cnt_r;
      tick_nxt = 1'b0;
      if (!enable) begin
         acc_nxt = '0;
         cnt_nxt = reload;
      end else if (sum[FRAC_W]) begin
         if (cnt_r == '0) begin
            cnt_nxt  = reload; // R10
            tick_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r - 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         acc_r  <= '0;
         cnt_r  <= '0;
         tick_r <= 1'b0;
      end else begin
         acc_r  <= acc_nxt;
         cnt_r  <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick = tick_r;
endmodule

// [hdl/asp_top.sv]
// The address map and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ns
module asp_top #(
   parameter int BAUD_W = asp_pkg::BAUD_W_DEF
) (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output      logic [31:0] hrdata,
   output      logic        hreadyout,
   output      logic        hresp,
   input  wire logic        rxdIn,
   output      logic        rxdOut,
   output      logic        rxdOe,
   output      logic        txdOut,
   output      logic        irq
);
   if (BAUD_W != 13) begin : gCheck
      $error("asp_top: baud counter must be 13 bits");
   end

   // ***************
   // bus slave
   // ***************
   logic              wrPend_r, wrPend_nxt, rdPend_r, rdPend_nxt;
   logic [7:0]        addr_r, addr_nxt;
   logic [31:0]       hrdata_r, hrdata_nxt;
   logic              accept;

   function automatic logic hit(input logic pend, input logic [7:0] a, input logic [7:0] off);
      hit = pend && (a == off);
   endfunction

   assign accept    = hsel && htrans[1] && hready;
   assign hreadyout = !rdPend_r;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_r;

   // ***************
   // registers and buffers
   // ***************
   logic [asp_pkg::CTRL_W-1:0]   ctrl_r, ctrl_nxt;
   logic [BAUD_W-1:0]            baud_r, baud_nxt;
   logic [asp_pkg::FRAC_W_DEF:0] frac_r, frac_nxt;
   logic [asp_pkg::IRQ_W-1:0]    mask_r, mask_nxt, istat_r, istat_nxt, iset;
   logic [8:0]                   txBuf_r, txBuf_nxt, rxBuf_r, rxBuf_nxt;
   logic                         txFull_r, txFull_nxt, rxFull_r, rxFull_nxt;
   logic                         irq_r, irq_nxt;
   logic                         rxMeta_r, rxSync_r, rxPrev_r;
   logic                         tick, run, sync, nine, rdRx;

   assign run  = ctrl_r[asp_pkg::CB_RUN];
   assign sync = ctrl_r[asp_pkg::CB_SYNC];
   assign nine = ctrl_r[asp_pkg::CB_NINE] && !sync;
   assign rdRx = hit(rdPend_r, addr_r, asp_pkg::OFF_RXDATA);

   asp_baud_gen #(
      .CNT_W    (BAUD_W),
      .FRAC_W   (asp_pkg::FRAC_W_DEF)
   ) uBaud (
      .clk      (clk),
      .rstn     (rstn),
      .enable   (run),
      .reload   (baud_r),
      .fracStep (frac_r),
      .tick     (tick)
   );

   // ***************
   // transmit and sync engine
   // ***************
   asp_pkg::asp_tx_t txSt_r, txSt_nxt;
   logic [3:0]       txCnt_r, txCnt_nxt, txBit_r, txBit_nxt;
   logic [8:0]       txSh_r, txSh_nxt;
   logic             txPar_r, txPar_nxt, txd_r, txd_nxt, dOut_r, dOut_nxt, dOe_r, dOe_nxt;
   logic             syncRx_r, syncRx_nxt, txStop2_r, txStop2_nxt;
   logic             txLoad, tlastEv, sRxDone, endBit;
   logic [3:0]       lastBit;

   assign lastBit = nine ? asp_pkg::LAST9 : asp_pkg::LAST8;

   always_comb begin
      txSt_nxt    = txSt_r;
      txCnt_nxt   = tick ? txCnt_r + 4'h1 : txCnt_r;
      txBit_nxt   = txBit_r;
      txSh_nxt    = txSh_r;
      txPar_nxt   = txPar_r;
      txd_nxt     = txd_r;
      dOut_nxt    = dOut_r;
      dOe_nxt     = dOe_r;
      syncRx_nxt  = syncRx_r;
      txStop2_nxt = txStop2_r;
      txLoad      = 1'b0;
      tlastEv     = 1'b0;
      sRxDone     = 1'b0;
      endBit      = tick && txCnt_r == asp_pkg::OVS_LAST; // R15
      unique case (txSt_r)
         asp_pkg::TX_IDLE: begin
            txd_nxt   = 1'b1; // R17
            dOe_nxt   = 1'b0;
            txCnt_nxt = 4'h0;
            txBit_nxt = 4'h0;
            if (run && txFull_r) begin
               txLoad     = 1'b1; // R7
               txSh_nxt   = nine ? txBuf_r : {1'b0, txBuf_r[7:0]};
               txPar_nxt  = ^(nine ? txBuf_r : {1'b0, txBuf_r[7:0]}) ^ ctrl_r[asp_pkg::CB_ODD]; // R4
               syncRx_nxt = 1'b0;
               txd_nxt    = 1'b0; // R17
               if (sync) begin
                  txSt_nxt = asp_pkg::TX_SYNC; // R1
                  dOut_nxt = txBuf_r[0];
                  dOe_nxt  = 1'b1;
               end else begin
                  txSt_nxt = asp_pkg::TX_START;
               end
            end else if (run && sync && ctrl_r[asp_pkg::CB_REN]) begin
               txSt_nxt   = asp_pkg::TX_SYNC; // R1
               syncRx_nxt = 1'b1;
               txSh_nxt   = 9'h000;
               txd_nxt    = 1'b0;
            end
         end
         asp_pkg::TX_START: begin
            if (endBit) begin
               txd_nxt  = txSh_r[0]; // R3
               txSh_nxt = txSh_r >> 1;
               txSt_nxt = asp_pkg::TX_DATA;
            end
         end
         asp_pkg::TX_DATA: begin
            if (endBit) begin
               if (txBit_r != lastBit) begin
                  txBit_nxt = txBit_r + 4'h1;
                  txd_nxt   = txSh_r[0]; // R3
                  txSh_nxt  = txSh_r >> 1;
               end else if (ctrl_r[asp_pkg::CB_PAR]) begin
                  txd_nxt  = txPar_r; // R4
                  txSt_nxt = asp_pkg::TX_PAR;
               end else begin
                  txd_nxt     = 1'b1;
                  txStop2_nxt = ctrl_r[asp_pkg::CB_STOP2]; // R5
                  txSt_nxt    = asp_pkg::TX_STOP;
               end
            end
         end
         asp_pkg::TX_PAR: begin
            if (endBit) begin
               txd_nxt     = 1'b1;
               txStop2_nxt = ctrl_r[asp_pkg::CB_STOP2]; // R5
               txSt_nxt    = asp_pkg::TX_STOP;
            end
         end
         asp_pkg::TX_STOP: begin
            if (endBit) begin
               if (txStop2_r) begin
                  txStop2_nxt = 1'b0; // R5
               end else begin
                  tlastEv  = 1'b1; // R12
                  txSt_nxt = asp_pkg::TX_IDLE;
               end
            end
         end
         asp_pkg::TX_SYNC: begin
            if (tick && txCnt_r == asp_pkg::SYNC_RISE) begin
               txd_nxt = 1'b1; // R2
               if (syncRx_r) begin
                  txSh_nxt = {1'b0, rxSync_r, txSh_r[7:1]};
               end
            end
            if (tick && txCnt_r == asp_pkg::SYNC_LAST) begin
               txCnt_nxt = 4'h0; // R16
               if (txBit_r == asp_pkg::LAST8) begin
                  txSt_nxt = asp_pkg::TX_IDLE;
                  sRxDone  = syncRx_r;
                  tlastEv  = !syncRx_r; // R12
               end else begin
                  txBit_nxt = txBit_r + 4'h1;
                  txd_nxt   = 1'b0; // R2
                  if (!syncRx_r) begin
                     dOut_nxt = txSh_r[1];
                     txSh_nxt = txSh_r >> 1;
                  end
               end
            end
         end
      endcase
      if (!run) begin
         txSt_nxt = asp_pkg::TX_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         txSt_r    <= asp_pkg::TX_IDLE;
         txCnt_r   <= 4'h0;
         txBit_r   <= 4'h0;
         txSh_r    <= 9'h000;
         txPar_r   <= 1'b0;
         txd_r     <= 1'b1;
         dOut_r    <= 1'b1;
         dOe_r     <= 1'b0;
         syncRx_r  <= 1'b0;
         txStop2_r <= 1'b0;
      end else begin
         txSt_r    <= txSt_nxt;
         txCnt_r   <= txCnt_nxt;
         txBit_r   <= txBit_nxt;
         txSh_r    <= txSh_nxt;
         txPar_r   <= txPar_nxt;
         txd_r     <= txd_nxt;
         dOut_r    <= dOut_nxt;
         dOe_r     <= dOe_nxt;
         syncRx_r  <= syncRx_nxt;
         txStop2_r <= txStop2_nxt;
      end
   end

   assign txdOut = txd_r;
   assign rxdOut = dOut_r;
   assign rxdOe  = dOe_r;

   // ***************
   // async receiver
   // ***************
   asp_pkg::asp_rx_t rxSt_r, rxSt_nxt;
   logic [3:0]       rxCnt_r, rxCnt_nxt, rxBit_r, rxBit_nxt;
   logic [8:0]       rxSh_r, rxSh_nxt, rxData;
   logic [1:0]       vote_r, vote_nxt;
   logic             rxPbit_r, rxPbit_nxt, rxFe_r, rxFe_nxt, rxStop2_r, rxStop2_nxt;
   logic             rxIn, voteBit, aRxDone, aRxKeep, peEv, feEv;

   assign rxIn = ctrl_r[asp_pkg::CB_LOOP] ? txd_r : rxSync_r; // R9

   always_comb begin
      rxSt_nxt    = rxSt_r;
      rxCnt_nxt   = tick ? rxCnt_r + 4'h1 : rxCnt_r;
      rxBit_nxt   = rxBit_r;
      rxSh_nxt    = rxSh_r;
      vote_nxt    = vote_r;
      rxPbit_nxt  = rxPbit_r;
      rxFe_nxt    = rxFe_r;
      rxStop2_nxt = rxStop2_r;
      aRxDone     = 1'b0;
      voteBit     = (vote_r[0] & vote_r[1]) | (vote_r[0] & rxIn) | (vote_r[1] & rxIn); // R18
      rxData      = nine ? rxSh_r : {1'b0, rxSh_r[8:1]};
      if (tick && rxCnt_r == asp_pkg::VOTE_A) vote_nxt[0] = rxIn; // R18
      if (tick && rxCnt_r == asp_pkg::VOTE_B) vote_nxt[1] = rxIn;
      unique case (rxSt_r)
         asp_pkg::RX_IDLE: begin
            rxCnt_nxt = 4'h0;
            rxBit_nxt = 4'h0;
            rxFe_nxt  = 1'b0;
            if (run && !sync && ctrl_r[asp_pkg::CB_REN] && rxPrev_r && !rxIn) begin
               rxSt_nxt = asp_pkg::RX_START; // R17
            end
         end
         asp_pkg::RX_START: begin
            if (tick && rxCnt_r == asp_pkg::VOTE_C && voteBit) rxSt_nxt = asp_pkg::RX_IDLE; // R17
            if (tick && rxCnt_r == asp_pkg::OVS_LAST) rxSt_nxt = asp_pkg::RX_DATA;
         end
         asp_pkg::RX_DATA: begin
            if (tick && rxCnt_r == asp_pkg::VOTE_C) rxSh_nxt = {voteBit, rxSh_r[8:1]}; // R3
            if (tick && rxCnt_r == asp_pkg::OVS_LAST) begin
               rxBit_nxt = rxBit_r + 4'h1;
               if (rxBit_r == lastBit) begin
                  rxStop2_nxt = ctrl_r[asp_pkg::CB_STOP2]; // R5
                  rxSt_nxt    = ctrl_r[asp_pkg::CB_PAR] ? asp_pkg::RX_PAR : asp_pkg::RX_STOP;
               end
            end
         end
         asp_pkg::RX_PAR: begin
            if (tick && rxCnt_r == asp_pkg::VOTE_C) rxPbit_nxt = voteBit; // R4
            if (tick && rxCnt_r == asp_pkg::OVS_LAST) rxSt_nxt = asp_pkg::RX_STOP;
         end
         asp_pkg::RX_STOP: begin
            if (tick && rxCnt_r == asp_pkg::VOTE_C) begin
               rxFe_nxt = rxFe_r | !voteBit; // R6
               if (rxStop2_r && voteBit) begin
                  rxStop2_nxt = 1'b0; // R5
               end else begin
                  aRxDone  = 1'b1;
                  rxSt_nxt = asp_pkg::RX_IDLE;
               end
            end
         end
      endcase
      if (!run || sync) begin
         rxSt_nxt = asp_pkg::RX_IDLE;
      end
      aRxKeep = aRxDone && !(ctrl_r[asp_pkg::CB_MP] && nine && !rxData[8]); // R8
      peEv    = aRxKeep && ctrl_r[asp_pkg::CB_PAR] && ((^rxData) ^ ctrl_r[asp_pkg::CB_ODD]) != rxPbit_r; // R6
      feEv    = aRxKeep && rxFe_nxt; // R6
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         rxSt_r    <= asp_pkg::RX_IDLE;
         rxCnt_r   <= 4'h0;
         rxBit_r   <= 4'h0;
         rxSh_r    <= 9'h000;
         vote_r    <= 2'h3;
         rxPbit_r  <= 1'b0;
         rxFe_r    <= 1'b0;
         rxStop2_r <= 1'b0;
      end else begin
         rxSt_r    <= rxSt_nxt;
         rxCnt_r   <= rxCnt_nxt;
         rxBit_r   <= rxBit_nxt;
         rxSh_r    <= rxSh_nxt;
         vote_r    <= vote_nxt;
         rxPbit_r  <= rxPbit_nxt;
         rxFe_r    <= rxFe_nxt;
         rxStop2_r <= rxStop2_nxt;
      end
   end

   // pin synchroniser; rxPrev sees rxIn: the second stage, or txd_r in loop-back
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rxMeta_r <= 1'b1;
         rxSync_r <= 1'b1;
         rxPrev_r <= 1'b1;
      end else begin
         rxMeta_r <= rxdIn;
         rxSync_r <= rxMeta_r;
         rxPrev_r <= rxIn;
      end
   end

   // ***************
   // register file and events
   // ***************
   always_comb begin
      wrPend_nxt = accept && hwrite;
      rdPend_nxt = accept && !hwrite;
      addr_nxt   = accept ? haddr[7:0] : addr_r;
      hrdata_nxt = hrdata_r;
      if (rdPend_r) begin
         unique case (addr_r)
            asp_pkg::OFF_CTRL:   hrdata_nxt = {23'h000000, ctrl_r};
            asp_pkg::OFF_BAUD:   hrdata_nxt = {19'h00000, baud_r};
            asp_pkg::OFF_FRAC:   hrdata_nxt = {21'h000000, frac_r};
            asp_pkg::OFF_TXDATA: hrdata_nxt = {23'h000000, txBuf_r};
            asp_pkg::OFF_RXDATA: hrdata_nxt = {23'h000000, rxBuf_r};
            asp_pkg::OFF_STATUS: hrdata_nxt = {28'h0000000, txFull_r, txSt_r != asp_pkg::TX_IDLE,
                                               rxFull_r, rxSt_r != asp_pkg::RX_IDLE};
            asp_pkg::OFF_ISTAT:  hrdata_nxt = {26'h0000000, istat_r};
            asp_pkg::OFF_IMASK:  hrdata_nxt = {26'h0000000, mask_r};
            default:             hrdata_nxt = 32'h00000000;
         endcase
      end
      ctrl_nxt = hit(wrPend_r, addr_r, asp_pkg::OFF_CTRL) ? hwdata[asp_pkg::CTRL_W-1:0] : ctrl_r;
      baud_nxt = hit(wrPend_r, addr_r, asp_pkg::OFF_BAUD) ? hwdata[BAUD_W-1:0] : baud_r;
      frac_nxt = hit(wrPend_r, addr_r, asp_pkg::OFF_FRAC) ? hwdata[asp_pkg::FRAC_W_DEF:0] : frac_r;
      mask_nxt = hit(wrPend_r, addr_r, asp_pkg::OFF_IMASK) ? hwdata[asp_pkg::IRQ_W-1:0] : mask_r;
      // transmit buffer: a load by the engine loses to a fresh write
      txBuf_nxt  = txBuf_r;
      txFull_nxt = txFull_r && !txLoad; // R7
      if (hit(wrPend_r, addr_r, asp_pkg::OFF_TXDATA)) begin
         txBuf_nxt  = hwdata[8:0];
         txFull_nxt = 1'b1;
      end
      // receive buffer: arrival wins over the clearing read
      rxBuf_nxt  = rxBuf_r;
      rxFull_nxt = rxFull_r && !rdRx;
      if (aRxKeep || sRxDone) begin
         rxBuf_nxt  = sRxDone ? {1'b0, txSh_r[7:0]} : rxData; // R7
         rxFull_nxt = 1'b1;
      end
      iset = '0;
      iset[asp_pkg::IB_TBE]   = txLoad; // R11
      iset[asp_pkg::IB_TLAST] = tlastEv; // R12
      iset[asp_pkg::IB_RBF]   = aRxKeep || sRxDone; // R13
      iset[asp_pkg::IB_PE]    = peEv; // R14
      iset[asp_pkg::IB_FE]    = feEv; // R14
      iset[asp_pkg::IB_OE]    = (aRxKeep || sRxDone) && rxFull_r && !rdRx; // R6
      istat_nxt = istat_r;
      if (hit(wrPend_r, addr_r, asp_pkg::OFF_ISTAT)) begin
         istat_nxt = istat_r & ~hwdata[asp_pkg::IRQ_W-1:0];
      end
      istat_nxt = istat_nxt | iset;
      irq_nxt   = |(istat_nxt & mask_nxt);
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         wrPend_r <= 1'b0;
         rdPend_r <= 1'b0;
         addr_r   <= 8'h00;
         hrdata_r <= 32'h00000000;
         ctrl_r   <= asp_pkg::CTRL_RST;
         baud_r   <= '0;
         frac_r   <= asp_pkg::FRAC_RST;
         mask_r   <= asp_pkg::MASK_RST;
         istat_r  <= '0;
         txBuf_r  <= 9'h000;
         txFull_r <= 1'b0;
         rxBuf_r  <= 9'h000;
         rxFull_r <= 1'b0;
         irq_r    <= 1'b0;
      end else begin
         wrPend_r <= wrPend_nxt;
         rdPend_r <= rdPend_nxt;
         addr_r   <= addr_nxt;
         hrdata_r <= hrdata_nxt;
         ctrl_r   <= ctrl_nxt;
         baud_r   <= baud_nxt;
         frac_r   <= frac_nxt;
         mask_r   <= mask_nxt;
         istat_r  <= istat_nxt;
         txBuf_r  <= txBuf_nxt;
         txFull_r <= txFull_nxt;
         rxBuf_r  <= rxBuf_nxt;
         rxFull_r <= rxFull_nxt;
         irq_r    <= irq_nxt;
      end
   end

   assign irq = irq_r;
endmodule

// [tb/asp_asserts.sv]
`timescale 1ns/1ns
module asp_asserts #(
   parameter int BAUD_W = 13
) (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        rxdIn,
   input wire logic        rxdOut,
   input wire logic        rxdOe,
   input wire logic        txdOut,
   input wire logic        irq
);
   // **********
   // line high time
   // **********
   logic [7:0] highRun_r;
   logic [7:0] highRun_nxt;
   always_comb begin
      highRun_nxt = (!rstn || !txdOut) ? 8'h00 : highRun_r + {7'h00, highRun_r != 8'hff};
   end
   always_ff @(posedge clk) begin
      highRun_r <= highRun_nxt;
   end
   // **********
   // properties
   // **********
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_rd; hsel && htrans[1] && hready && !hwrite; endsequence
   sequence s_wr; hsel && htrans[1] && hready && hwrite; endsequence
   sequence s_wait1; !hreadyout ##1 hreadyout; endsequence
   sequence s_mask0; s_wr ##0 haddr[7:0] == asp_pkg::OFF_IMASK ##1 hwdata[5:0] == 6'h00; endsequence
   a_resp_okay: assert property (hresp == 1'b0) else $error("error response");
   a_read_wait: assert property (s_rd |=> s_wait1) else $error("read wait not one cycle");
   a_write_nowait: assert property (s_wr |=> hreadyout) else $error("write stalled");
   a_upper_zero: assert property (s_rd |-> ##2 hrdata[31:11] == 21'h0) else $error("upper bits set");
   a_reset_idle: assert property ($rose(rstn) |-> txdOut && !rxdOe && !irq)
      else $error("line not idle after reset");
   a_bit_high: assert property ($fell(txdOut) |-> highRun_r >= 8'h03)
      else $error("line high too short");
   a_sync_hold: assert property (rxdOe && txdOut && $past(rxdOe) && $past(txdOut) |-> $stable(rxdOut))
      else $error("sync data moved while clock high");
   a_mask_off: assert property (s_mask0 |-> ##[1:3] !irq) else $error("irq with mask cleared");
endmodule
bind asp_top asp_asserts #(.BAUD_W(BAUD_W)) asp_asserts_inst (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite,
   .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .rxdIn, .rxdOut, .rxdOe, .txdOut, .irq);

// [tb/asp_partner.sv]
`timescale 1ns/1ns
module asp_partner (
   input  wire logic clk,
   input  wire logic lineIn,
   input  wire logic dataIn,
   output      logic lineOut
);
   int         bitLen = 16;
   int         nBits = 8;
   int         stops = 1;
   logic       syncMode = 1'b0;
   logic [8:0] got;
   initial lineOut = 1'b1;
   task automatic cfg(input int len, input int n, input int s, input logic sm);
      bitLen = len;
      nBits = n;
      stops = s;
      syncMode = sm;
   endtask
   // **********
   // async sender
   // **********
   task automatic send(input logic [8:0] d, input int n, input int s, input logic stopVal);
      lineOut <= 1'b0;
      repeat (bitLen) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         lineOut <= d[i];
         repeat (bitLen) @(posedge clk);
      end
      repeat (s) begin
         lineOut <= stopVal;
         repeat (bitLen) @(posedge clk);
      end
      lineOut <= 1'b1;
      repeat (2 * bitLen) @(posedge clk);
   endtask
   // **********
   // receiver, mid-bit or on clock rise
   // **********
   always begin
      @(negedge lineIn);
      got = 9'h000;
      if (syncMode) begin
         for (int i = 0; i < 8; i++) begin
            @(posedge lineIn);
            @(posedge clk);
            got[i] = dataIn;
            if (i < 7) @(negedge lineIn);
         end
      end else begin
         repeat (bitLen / 2) @(posedge clk);
         for (int i = 0; i < nBits; i++) begin
            repeat (bitLen) @(posedge clk);
            got[i] = lineIn;
         end
      end
   end
endmodule

// [tb/async_sync_serial_port_tb.sv]
`timescale 1ns/1ns
module async_sync_serial_port_tb;
   logic        clk;
   logic        rstn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        rxdOut;
   logic        rxdOe;
   logic        txdOut;
   logic        irq;
   logic        partLine;
   logic [31:0] rdVal;
   int          num_errors = 0;
   int          comparisons = 0;
   wire logic   rxLine = rxdOe ? rxdOut : partLine;

   asp_top asp_top_inst (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
      .hrdata, .hreadyout, .hresp(), .rxdIn(rxLine), .rxdOut, .rxdOe, .txdOut, .irq);
   asp_partner asp_partner_inst (.clk, .lineIn(txdOut), .dataIn(rxLine), .lineOut(partLine));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // **********
   // checking and bus tasks
   // **********
   task automatic give_verdict;
      $display("comparisons %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic hang;
      num_errors++;
      $display("[ERR] %0t wait bound used up", $time);
      give_verdict;
   endtask
   task automatic waitReady;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         if (++n > 50) hang;
      end while (hreadyout !== 1'b1);
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {24'h000000, a};
      waitReady;
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      waitReady;
      rdVal = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rdVal, exp);
   endtask
   task automatic waitBit(input int b);
      int n;
      n = 0;
      do begin
         bus(1'b0, 8'h18, 32'h0);
         if (++n > 1000) hang;
      end while (rdVal[b] !== 1'b1);
   endtask
   // **********
   // main sequence
   // **********
   initial begin
      rstn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = 32'h0;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rdc(8'h00, 32'h0);
      rdc(8'h04, 32'h0);
      rdc(8'h08, 32'h400);
      rdc(8'h18, 32'h0);
      rdc(8'h20, 32'h0);
      wr(8'h1c, 32'h3f);
      asp_partner_inst.cfg(16, 9, 2, 1'b0);
      wr(8'h00, 32'h194);
      wr(8'h0c, 32'ha4);
      wr(8'h0c, 32'h5b);
      rdc(8'h14, 32'hc);
      waitBit(1);
      wr(8'h18, 32'h3f);
      waitBit(1);
      chk({23'h0, asp_partner_inst.got}, 32'h15b);
      rdc(8'h18, 32'h2);
      chk({31'h0, irq}, 32'h1);
      wr(8'h18, 32'h3f);
      asp_partner_inst.send(9'h03c, 9, 2, 1'b1);
      waitBit(2);
      rdc(8'h10, 32'h3c);
      asp_partner_inst.send(9'h13c, 9, 2, 1'b1);
      waitBit(3);
      asp_partner_inst.send(9'h03c, 9, 2, 1'b0);
      waitBit(4);
      bus(1'b0, 8'h10, 32'h0);
      wr(8'h18, 32'h3f);
      asp_partner_inst.send(9'h03c, 9, 2, 1'b1);
      asp_partner_inst.send(9'h05a, 9, 2, 1'b1);
      waitBit(5);
      rdc(8'h10, 32'h5a);
      asp_partner_inst.cfg(64, 8, 1, 1'b0);
      wr(8'h00, 32'h180);
      wr(8'h04, 32'h1);
      wr(8'h08, 32'h200);
      wr(8'h0c, 32'h96);
      waitBit(1);
      chk({23'h0, asp_partner_inst.got}, 32'h96);
      wr(8'h04, 32'h0);
      wr(8'h08, 32'h400);
      asp_partner_inst.cfg(16, 8, 1, 1'b0);
      wr(8'h18, 32'h3f);
      wr(8'h00, 32'h1ce);
      wr(8'h0c, 32'h1a5);
      waitBit(2);
      rdc(8'h10, 32'h1a5);
      waitBit(1);
      rdc(8'h18, 32'h7);
      wr(8'h00, 32'h1a2);
      wr(8'h18, 32'h3f);
      asp_partner_inst.send(9'h055, 9, 1, 1'b1);
      asp_partner_inst.send(9'h1c3, 9, 1, 1'b1);
      waitBit(2);
      rdc(8'h10, 32'h1c3);
      rdc(8'h18, 32'h4);
      asp_partner_inst.cfg(16, 8, 1, 1'b1);
      wr(8'h18, 32'h3f);
      wr(8'h00, 32'h101);
      wr(8'h0c, 32'h4b);
      waitBit(1);
      chk({23'h0, asp_partner_inst.got}, 32'h4b);
      wr(8'h00, 32'h181);
      waitBit(2);
      rdc(8'h10, 32'hff);
      asp_partner_inst.cfg(16, 8, 1, 1'b0);
      wr(8'h00, 32'h100);
      wr(8'h1c, 32'h1);
      wr(8'h18, 32'h3f);
      wr(8'h0c, 32'h11);
      waitBit(1);
      chk({31'h0, irq}, 32'h1);
      wr(8'h1c, 32'h0);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      wr(8'h1c, 32'h1);
      wr(8'h18, 32'h1);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      give_verdict;
   end
endmodule
